// [rtl/status_led_pkg.sv]
package status_led_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned MS_PER_S       = 1000;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / MS_PER_S;
	localparam int unsigned SIGNAL_HALF_MS = 500;
	localparam int unsigned SIGNAL_TOTAL_S = 3;
	localparam int unsigned SIGNAL_TOTAL_MS = SIGNAL_TOTAL_S * MS_PER_S;
	localparam int unsigned NODATA_HALF_MS = 250;
	localparam int unsigned ACT_HALF_MS    = 50;
	localparam int unsigned MS_W           = 12;
	localparam int unsigned TICK_W         = 14;
	localparam int unsigned NUM_CH         = 2;
	// Crossover hunt dwell before swapping pairs
	localparam int unsigned MDIX_DWELL_MS  = 100;

	// ************************************************************
	// Line rate encoding
	// ************************************************************
	localparam logic RATE_10M  = 1'h0;
	localparam logic RATE_100M = 1'h1;
endpackage : status_led_pkg

// [rtl/rt_ethernet_status_led_driver.sv]
// Operation
// [RL1] Discovery signal request flashes system-failure LED red at 1 Hz for 3 s.
// [RL2] System-failure LED steady on watchdog, diagnosis or system error, else off.
// [RL3] No cyclic data exchange flashes bus-failure LED at 2 Hz, 250/250 ms.
// [RL4] Bus-failure LED steady on no config, low-speed link or no link.
// [RL5] Signal flash is 500 ms on, 500 ms off, 3 s total, then normal.
// [RL6] Green link LED on per channel while that channel has link.
// [RL7] Yellow traffic LED flickers per channel with frames, off without.
// [RL8] Heavy traffic toggles traffic LED at about 10 Hz, 50/50 ms.
// [RL9] Light traffic toggles traffic LED on individual frame events.
// [RL10] Port detects cable type and swaps receive and transmit pairs.
// [RL11] Each port runs at 10 or 100 MBit/s over two pairs.
// [RL12] Blinks use one millisecond tick; patterns restart on state change.
`timescale 1ns/100ps
module rt_ethernet_status_led_driver #(
	parameter int unsigned NUM_CH      = status_led_pkg::NUM_CH,
	// Cycles per millisecond tick; a short tick lets simulation reach second-scale patterns
	parameter int unsigned TICK_CYCLES = status_led_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_reset,
	// Protocol stack flags, same clock domain
	input  wire logic              i_discovery_signal_request,
	input  wire logic              i_watchdog_timeout,
	input  wire logic              i_diagnosis_present,
	input  wire logic              i_system_error,
	input  wire logic              i_no_data_exchange,
	input  wire logic              i_no_configuration,
	// PHY indications, asynchronous
	input  wire logic [NUM_CH-1:0] i_phy_link,
	input  wire logic [NUM_CH-1:0] i_phy_speed_100,
	input  wire logic [NUM_CH-1:0] i_phy_frame,
	// Pair swap and rate
	output logic      [NUM_CH-1:0] o_mdix_swap,
	output logic      [NUM_CH-1:0] o_line_rate,
	// LEDs
	output logic                   o_system_failure_led,
	output logic                   o_bus_failure_led,
	output logic      [NUM_CH-1:0] o_link_led,
	output logic      [NUM_CH-1:0] o_traffic_led
);
	localparam int unsigned TW = status_led_pkg::TICK_W;
	localparam int unsigned MW = status_led_pkg::MS_W;
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
	localparam logic [MW-1:0] SIG_HALF  = MW'(status_led_pkg::SIGNAL_HALF_MS - 1);
	localparam logic [MW-1:0] SIG_TOTAL = MW'(status_led_pkg::SIGNAL_TOTAL_MS - 1);
	localparam logic [MW-1:0] ND_HALF   = MW'(status_led_pkg::NODATA_HALF_MS - 1);
	localparam logic [MW-1:0] ACT_HALF  = MW'(status_led_pkg::ACT_HALF_MS - 1);
	localparam logic [MW-1:0] DWELL     = MW'(status_led_pkg::MDIX_DWELL_MS - 1);

	typedef enum logic [1:0] {BUS_OFF, BUS_FLASH, BUS_STEADY} bus_mode_e;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [TW-1:0]         tick_cnt;
		logic                  req_prev;
		logic                  sig_active;
		logic [MW-1:0]         sig_total;
		logic [MW-1:0]         sig_phase;
		logic                  sig_on;
		bus_mode_e             bus_mode;
		logic [MW-1:0]         bus_phase;
		logic                  bus_on;
		logic [NUM_CH-1:0]     link_s1;
		logic [NUM_CH-1:0]     link_s2;
		logic [NUM_CH-1:0]     spd_s1;
		logic [NUM_CH-1:0]     spd_s2;
		logic [NUM_CH-1:0]     frm_s1;
		logic [NUM_CH-1:0]     frm_s2;
		logic [NUM_CH-1:0]     frm_prev;
		logic [NUM_CH-1:0]     act_busy;
		logic [NUM_CH-1:0]     act_pend;
		logic [NUM_CH*MW-1:0]  act_phase;
		logic [NUM_CH-1:0]     swap;
		logic [NUM_CH*MW-1:0]  hunt;
		logic                  sys_led;
		logic                  bus_led;
		logic [NUM_CH-1:0]     link_led;
		logic [NUM_CH-1:0]     act_led;
	} state_s;

	state_s st_q;
	state_s st_d;
	logic   ms_tick;
	logic   any_steady_bus;
	logic   sys_err;
	bus_mode_e bus_sel;

	// ************************************************************
	// Millisecond tick and shared flags
	// ************************************************************
	assign ms_tick = (st_q.tick_cnt == TICK_LAST); // RL12
	assign sys_err = i_watchdog_timeout | i_diagnosis_present | i_system_error;
	// Low speed means not at 100 MBit/s on any linked port
	assign any_steady_bus = i_no_configuration | ~(|st_q.link_s2) |
		~(|(st_q.link_s2 & st_q.spd_s2)); // RL4
	// Steady beats flash
	assign bus_sel = any_steady_bus ? BUS_STEADY : (i_no_data_exchange ? BUS_FLASH : BUS_OFF);

	always_comb begin
		st_d = st_q;
		st_d.tick_cnt = ms_tick ? '0 : st_q.tick_cnt + TW'(1);
		st_d.link_s1  = i_phy_link;
		st_d.link_s2  = st_q.link_s1;
		st_d.spd_s1   = i_phy_speed_100;
		st_d.spd_s2   = st_q.spd_s1;
		st_d.frm_s1   = i_phy_frame;
		st_d.frm_s2   = st_q.frm_s1;
		st_d.frm_prev = st_q.frm_s2;
		st_d.req_prev = i_discovery_signal_request;

		// ************************************************************
		// Timed signal flash, retriggered by a new request
		// ************************************************************
		if (i_discovery_signal_request && !st_q.req_prev) begin
			st_d.sig_active = 1'b1; // RL1
			st_d.sig_total  = '0;
			st_d.sig_phase  = '0; // RL12
			st_d.sig_on     = 1'b1;
		end else if (st_q.sig_active && ms_tick) begin
			st_d.sig_total = st_q.sig_total + MW'(1);
			if (st_q.sig_total == SIG_TOTAL) begin
				st_d.sig_active = 1'b0; // RL5
			end
			if (st_q.sig_phase == SIG_HALF) begin
				st_d.sig_phase = '0;
				st_d.sig_on    = ~st_q.sig_on; // RL5
			end else begin
				st_d.sig_phase = st_q.sig_phase + MW'(1);
			end
		end
		// Signal flash overrides the steady error indication while it runs
		st_d.sys_led = st_d.sig_active ? st_d.sig_on : sys_err; // RL2

		// ************************************************************
		// Bus failure indication
		// ************************************************************
		st_d.bus_mode = bus_sel;
		if (bus_sel != st_q.bus_mode) begin
			st_d.bus_phase = '0; // RL12
			st_d.bus_on    = 1'b1;
		end else if (ms_tick) begin
			if (st_q.bus_phase == ND_HALF) begin
				st_d.bus_phase = '0;
				st_d.bus_on    = ~st_q.bus_on; // RL3
			end else begin
				st_d.bus_phase = st_q.bus_phase + MW'(1);
			end
		end
		unique case (bus_sel)
			BUS_OFF:    st_d.bus_led = 1'b0;
			BUS_FLASH:  st_d.bus_led = st_d.bus_on; // RL3
			BUS_STEADY: st_d.bus_led = 1'b1; // RL4
			default:    st_d.bus_led = 1'b0;
		endcase

		// ************************************************************
		// Per channel link, traffic and crossover
		// ************************************************************
		for (int c = 0; c < NUM_CH; c++) begin
			st_d.link_led[c] = st_q.link_s2[c]; // RL6
			// A frame during a running flash is held, so bursts give a 10 Hz rhythm
			if (st_q.frm_s2[c] && !st_q.frm_prev[c] && st_q.link_s2[c]) begin
				st_d.act_pend[c] = 1'b1;
			end
			if (!st_q.link_s2[c]) begin
				st_d.act_busy[c] = 1'b0;
				st_d.act_pend[c] = 1'b0;
				st_d.act_led[c]  = 1'b0; // RL7
			end else if (!st_q.act_busy[c] && st_q.act_pend[c]) begin
				st_d.act_busy[c] = 1'b1; // RL9
				st_d.act_pend[c] = st_q.frm_s2[c] && !st_q.frm_prev[c];
				st_d.act_led[c]  = 1'b1; // RL7
				st_d.act_phase[c*MW +: MW] = '0;
			end else if (st_q.act_busy[c] && ms_tick) begin
				if (st_q.act_phase[c*MW +: MW] == ACT_HALF) begin
					st_d.act_phase[c*MW +: MW] = '0;
					st_d.act_led[c] = 1'b0; // RL8
					st_d.act_busy[c] = st_q.act_led[c];
				end else begin
					st_d.act_phase[c*MW +: MW] = st_q.act_phase[c*MW +: MW] + MW'(1);
				end
			end
			// No link: alternate straight and crossed pairs until one links
			if (st_q.link_s2[c]) begin
				st_d.hunt[c*MW +: MW] = '0; // RL10
			end else if (ms_tick) begin
				if (st_q.hunt[c*MW +: MW] == DWELL) begin
					st_d.hunt[c*MW +: MW] = '0;
					st_d.swap[c] = ~st_q.swap[c]; // RL10
				end else begin
					st_d.hunt[c*MW +: MW] = st_q.hunt[c*MW +: MW] + MW'(1);
				end
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_system_failure_led = st_q.sys_led;
	assign o_bus_failure_led    = st_q.bus_led;
	assign o_link_led           = st_q.link_led;
	assign o_traffic_led        = st_q.act_led;
	assign o_mdix_swap          = st_q.swap;
	// Rate follows the PHY's resolved speed: 1 = 100, 0 = 10 MBit/s
	assign o_line_rate          = st_q.spd_s2; // RL11
endmodule : rt_ethernet_status_led_driver

// [verification/led_props.sv]
`timescale 1ns/100ps
module led_props #(
	parameter int unsigned NUM_CH = 2
) (
	input wire logic              i_mclk,
	input wire logic              i_reset,
	input wire logic              i_discovery_signal_request,
	input wire logic              i_no_data_exchange,
	input wire logic              i_no_configuration,
	input wire logic [NUM_CH-1:0] i_phy_link,
	input wire logic [NUM_CH-1:0] i_phy_speed_100,
	input wire logic [NUM_CH-1:0] i_phy_frame,
	input wire logic [NUM_CH-1:0] o_mdix_swap,
	input wire logic [NUM_CH-1:0] o_line_rate,
	input wire logic              o_system_failure_led,
	input wire logic              o_bus_failure_led,
	input wire logic [NUM_CH-1:0] o_link_led,
	input wire logic [NUM_CH-1:0] o_traffic_led
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	// Five samples cover the two-stage synchroniser plus the output register
	AST_SYS_START: assert property ($rose(i_discovery_signal_request) |=> o_system_failure_led [*8]) else $error("system flash");
	AST_BUS_CONF: assert property (i_no_configuration |=> o_bus_failure_led) else $error("bus config");
	AST_BUS_NOLINK: assert property ((i_phy_link == '0) [*5] |-> o_bus_failure_led) else $error("bus link");
	AST_BUS_OFF: assert property ((!i_no_configuration && !i_no_data_exchange && i_phy_link[0] && i_phy_speed_100[0]) [*5]
		|-> !o_bus_failure_led) else $error("bus off");
	AST_LINK_ON: assert property (i_phy_link[0] [*5] |-> o_link_led[0]) else $error("link on");
	AST_LINK_OFF: assert property ((!i_phy_link[0]) [*5] |-> !o_link_led[0]) else $error("link off");
	AST_RATE: assert property (i_phy_speed_100[0] [*5] |-> o_line_rate[0]) else $error("rate");
	AST_ACT_HOLD: assert property ($rose(o_traffic_led[0]) |=> o_traffic_led[0] [*8]) else $error("act hold");
	AST_MDIX: assert property (i_phy_link[0] [*6] |-> $stable(o_mdix_swap[0])) else $error("mdix");
endmodule : led_props
bind rt_ethernet_status_led_driver led_props #(.NUM_CH(NUM_CH)) i_props (.i_mclk, .i_reset,
	.i_discovery_signal_request, .i_no_data_exchange, .i_no_configuration, .i_phy_link, .i_phy_speed_100,
	.i_phy_frame, .o_mdix_swap, .o_line_rate, .o_system_failure_led, .o_bus_failure_led, .o_link_led, .o_traffic_led);

// [verification/phy_far_end.sv]
`timescale 1ns/100ps
module phy_far_end (
	input  wire logic [1:0] i_link_req,
	input  wire logic       i_fast,
	input  wire logic [1:0] i_send,
	output logic      [1:0] o_link,
	output logic      [1:0] o_speed_100,
	output logic      [1:0] o_frame
);
	// No speed and no frames without a link
	assign o_link      = i_link_req;
	assign o_speed_100 = {2{i_fast}} & i_link_req;
	assign o_frame     = i_send & i_link_req;
endmodule : phy_far_end

// [verification/rt_ethernet_status_led_driver_tb_top.sv]
`timescale 1ns/100ps
module rt_ethernet_status_led_driver_tb_top;
	logic       i_mclk, i_reset, i_discovery_signal_request, i_watchdog_timeout, i_diagnosis_present;
	logic       i_system_error, i_no_data_exchange, i_no_configuration, fast, o_system_failure_led, o_bus_failure_led;
	logic [1:0] link_req, send, i_phy_link, i_phy_speed_100, i_phy_frame;
	logic [1:0] o_mdix_swap, o_line_rate, o_link_led, o_traffic_led, swap0;
	int         err_total = 0;
	int         checks = 0;
	phy_far_end i_phy (.i_link_req(link_req), .i_fast(fast), .i_send(send), .o_link(i_phy_link),
		.o_speed_100(i_phy_speed_100), .o_frame(i_phy_frame));
	rt_ethernet_status_led_driver #(.NUM_CH(2), .TICK_CYCLES(10)) i_dut (.i_mclk, .i_reset,
		.i_discovery_signal_request, .i_watchdog_timeout,
		.i_diagnosis_present, .i_system_error, .i_no_data_exchange, .i_no_configuration, .i_phy_link,
		.i_phy_speed_100, .i_phy_frame, .o_mdix_swap, .o_line_rate, .o_system_failure_led, .o_bus_failure_led,
		.o_link_led, .o_traffic_led);
	task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %b expected %b", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : cyc
	task automatic end_sim;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic sc_link;
		@(posedge i_mclk) link_req <= 2'h3;
		cyc(6);
		chk(o_link_led, 2'h3);
		chk(o_line_rate, 2'h3);
		chk(o_bus_failure_led, 1'h0);
		@(posedge i_mclk) fast <= 1'h0;
		cyc(6);
		chk(o_line_rate, 2'h0);
		chk(o_bus_failure_led, 1'h1);
		@(posedge i_mclk) fast <= 1'h1;
		cyc(6);
	endtask : sc_link
	task automatic sc_errors;
		for (int k = 0; k < 3; k++) begin
			@(posedge i_mclk) {i_watchdog_timeout, i_diagnosis_present, i_system_error} <= 3'h1 << k;
			cyc(2);
			chk(o_system_failure_led, 1'h1);
			@(posedge i_mclk) {i_watchdog_timeout, i_diagnosis_present, i_system_error} <= 3'h0;
			cyc(2);
			chk(o_system_failure_led, 1'h0);
		end
	endtask : sc_errors
	task automatic sc_bus;
		@(posedge i_mclk) i_no_configuration <= 1'h1;
		cyc(2);
		chk(o_bus_failure_led, 1'h1);
		@(posedge i_mclk) begin
			i_no_configuration <= 1'h0;
			i_no_data_exchange <= 1'h1;
		end
		cyc(200);
		chk(o_bus_failure_led, 1'h1);
		cyc(2500);
		chk(o_bus_failure_led, 1'h0);
		@(posedge i_mclk) i_no_data_exchange <= 1'h0;
		cyc(3);
		chk(o_bus_failure_led, 1'h0);
	endtask : sc_bus
	task automatic sc_traffic;
		@(posedge i_mclk) send <= 2'h1;
		@(posedge i_mclk) send <= 2'h0;
		for (int i = 0; i < 8 && o_traffic_led[0] !== 1'h1; i++)
			cyc(1);
		chk(o_traffic_led, 2'h1);
		cyc(20);
		chk(o_traffic_led, 2'h1);
		cyc(520);
		chk(o_traffic_led, 2'h0);
	endtask : sc_traffic
	task automatic sc_discovery;
		@(posedge i_mclk) i_discovery_signal_request <= 1'h1;
		cyc(2);
		chk(o_system_failure_led, 1'h1);
		@(posedge i_mclk) i_discovery_signal_request <= 1'h0;
		cyc(7000);
		chk(o_system_failure_led, 1'h0);
		cyc(5000);
		chk(o_system_failure_led, 1'h1);
		cyc(18100);
		chk(o_system_failure_led, 1'h0);
	endtask : sc_discovery
	initial begin
		i_mclk = 1'h0;
		forever #50 i_mclk = ~i_mclk;
	end
	initial begin
		#9000000;
		err_total++;
		end_sim();
	end
	initial begin
		{i_reset, fast} = 2'h3;
		{i_discovery_signal_request, i_watchdog_timeout, i_diagnosis_present} = 3'h0;
		{i_system_error, i_no_data_exchange, i_no_configuration, link_req, send} = 7'h0;
		cyc(2);
		chk({o_system_failure_led, o_bus_failure_led}, 2'h0);
		@(posedge i_mclk) i_reset <= 1'h0;
		cyc(2);
		chk(o_bus_failure_led, 1'h1);
		sc_link();
		sc_errors();
		sc_bus();
		sc_traffic();
		sc_discovery();
		@(posedge i_mclk) link_req <= 2'h0;
		cyc(6);
		chk(o_link_led, 2'h0);
		chk(o_bus_failure_led, 1'h1);
		swap0 = o_mdix_swap;
		cyc(1100);
		chk(o_mdix_swap, ~swap0);
		end_sim();
	end
endmodule : rt_ethernet_status_led_driver_tb_top
